// file: rei_pkg.sv
package rei_pkg;
  // ----------------------------------------
  // Slave address layout
  // ----------------------------------------
  localparam logic [3:0] REI_CTRL_CODE = 4'h1;  // Arbitrary value, set per product
  localparam int REI_CODE_MSB = 7;
  localparam int REI_CODE_LSB = 4;
  localparam int REI_SEL_MSB = 3;
  localparam int REI_SEL_LSB = 1;
  localparam int REI_RW_BIT = 0;
  localparam logic [2:0] REI_SEL_RTC = 3'h0;
  localparam logic [2:0] REI_SEL_LOW = 3'h1;
  localparam logic [2:0] REI_SEL_UP = 3'h2;

  // ----------------------------------------
  // Storage geometry
  // ----------------------------------------
  localparam int REI_PAGE_BYTES = 8;
  localparam logic [7:0] REI_RTC_BYTES = 8'h10;
  localparam int REI_MEM_WORDS = 768;
  localparam logic [2:0] REI_BIT_LAST = 3'h7;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int REI_CLK_HZ = 40000000;
  localparam int REI_WRITE_TIME_US = 5000;
  localparam int REI_WRITE_CYCLES = REI_WRITE_TIME_US * (REI_CLK_HZ / 1000000);

  // ----------------------------------------
  // Carriers and states
  // ----------------------------------------
  typedef struct packed {
    logic en;
    logic [9:0] addr;
    logic [7:0] data;
  } rei_wr_t;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} rei_state_t;
  typedef enum logic [1:0] {RL_ADDR, RL_WORD, RL_DATA} rei_role_t;
endpackage

// file: rei_sync.sv
module rei_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Asynchronous levels in, synchronised out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '1;
      sync_out <= '1;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// file: rei_mem.sv
module rei_mem (
  // Clock
  input wire logic clock,
  // Write port
  input wire rei_pkg::rei_wr_t wr,
  // Read port, data registered
  input wire logic [9:0] rd_addr,
  output logic [7:0] rd_data
);
  import rei_pkg::*;

  logic [7:0] mem [REI_MEM_WORDS];

  always_ff @(posedge clock) begin
    if (wr.en) begin
      mem[wr.addr] <= wr.data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// file: rei_slave.sv
// Contract
// - Buffer up to 8 page bytes
// - Commit page at STOP, start write cycle
// - Unwritten page bytes keep old contents
// - Pointer advances after each written byte
// - Page write wraps within page
// - Clock block writes not limited to 8
// - Clock block write wraps within block
// - Block select: 000 clock, 001/010 memory
// - Address LSB 1 read, 0 write
// - NACK memory address while cycle busy
// - Clock block usable during write cycle
// - Current read returns last location plus one
// - Random read keeps loaded pointer
// - Master ACK continues, NACK ends read
// - Memory reads wrap FFh to 00h in block, clock block reads 0Fh to 00h
// - Second write byte loads pointer, ACKed
// - Pages are aligned 8-byte regions
module rei_slave #(
  parameter int WRITE_CYCLES = rei_pkg::REI_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Status
  output logic write_busy
);
  import rei_pkg::*;

  // ----------------------------------------
  // Pin sampling and bus conditions
  // ----------------------------------------
  logic [1:0] pins_s;
  logic scl_d_r, sda_d_r;
  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // Lines idle high, so the reset values raise no false edge
  rei_sync #(.W(2)) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_s)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  rei_state_t st_r;
  rei_role_t role_r;
  logic [3:0] cnt_r;
  logic [7:0] rxsh_r, txsh_r;
  logic [7:0] ptr_r;
  logic [1:0] blk_r;
  logic rd_dir_r, more_r;
  logic [7:0] pbuf_r [REI_PAGE_BYTES];
  logic [7:0] pmask_r;
  logic [7:0] cmask_r;
  logic [4:0] ppage_r;
  logic [1:0] pblk_r;
  logic commit_r;
  logic [2:0] cidx_r;
  // Wide enough for the default cycle count
  logic [17:0] wcnt_r;
  logic [7:0] rd_data;

  // ----------------------------------------
  // Byte decode
  // ----------------------------------------
  // Only a byte being received; transmit keeps its own bit count
  wire byte_done = scl_fall & (cnt_r == 4'h8) & (st_r == ST_RX);
  wire [2:0] sel = rxsh_r[REI_SEL_MSB:REI_SEL_LSB];
  wire is_rtc_sel = (sel == REI_SEL_RTC);
  wire sel_ok = is_rtc_sel | (sel == REI_SEL_LOW) | (sel == REI_SEL_UP);
  wire code_ok = (rxsh_r[REI_CODE_MSB:REI_CODE_LSB] == REI_CTRL_CODE);
  wire addr_ack = code_ok & sel_ok & ~(write_busy & ~is_rtc_sel);
  wire blk_rtc = (blk_r == 2'h0);
  wire rx_ack = (role_r != RL_ADDR) | addr_ack;
  wire i2c_wr = byte_done & (role_r == RL_DATA) & blk_rtc;
  wire [7:0] rtc_next = (ptr_r + 8'h01 >= REI_RTC_BYTES) ? 8'h00 : ptr_r + 8'h01;
  wire [7:0] ptr_inc = blk_rtc ? rtc_next : ptr_r + 8'h01;
  wire [7:0] page_next = {ptr_r[7:3], ptr_r[2:0] + 3'h1};

  // ----------------------------------------
  // Commit sequencing
  // ----------------------------------------
  wire commit_start = bus_stop & (|pmask_r);
  wire commit_step = commit_r & ~i2c_wr;
  wire commit_last = commit_step & (cidx_r == REI_BIT_LAST);
  wire cycle_run = (wcnt_r > 18'h0_0001);
  wire commit_wr = commit_step & cmask_r[cidx_r];
  wire [17:0] wlen = 18'(WRITE_CYCLES);

  rei_wr_t wr_port;
  assign wr_port = '{
    en: i2c_wr | commit_wr,
    addr: i2c_wr ? {blk_r, ptr_r} : {pblk_r, ppage_r, cidx_r},
    data: i2c_wr ? rxsh_r : pbuf_r[cidx_r]
  };

  rei_mem u_mem (
    .clock(clock),
    .wr(wr_port),
    .rd_addr({blk_r, ptr_r}),
    .rd_data(rd_data)
  );

  // ----------------------------------------
  // Transmit load
  // ----------------------------------------
  // First bit leaves with the load; the rest go out on later SCL falls
  wire [7:0] tx_load = {rd_data[6:0], 1'b0};
  wire tx_load_oe = ~rd_data[7];
  wire tx_bit_oe = ~txsh_r[7];
  wire read_begin = rd_dir_r & (role_r == RL_WORD);

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_IDLE;
      role_r <= RL_ADDR;
      cnt_r <= 4'h0;
      rxsh_r <= 8'h00;
      txsh_r <= 8'h00;
      ptr_r <= 8'h00;
      blk_r <= 2'h0;
      rd_dir_r <= 1'b0;
      more_r <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      pmask_r <= 8'h00;
      ppage_r <= 5'h00;
      pblk_r <= 2'h0;
      for (int i = 0; i < REI_PAGE_BYTES; i++) begin
        pbuf_r[i] <= 8'h00;
      end
    end else if (bus_start) begin
      st_r <= ST_RX;
      role_r <= RL_ADDR;
      cnt_r <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      st_r <= ST_IDLE;
      sda_oe <= 1'b0;
      pmask_r <= 8'h00;
    end else begin
      case (st_r)
        ST_RX: begin
          if (scl_rise) begin
            rxsh_r <= {rxsh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_done) begin
            cnt_r <= 4'h0;
            sda_oe <= rx_ack;
            st_r <= rx_ack ? ST_RX_ACK : ST_IDLE;
            case (role_r)
              RL_ADDR: begin
                if (addr_ack) begin
                  blk_r <= sel[1:0];
                  rd_dir_r <= rxsh_r[REI_RW_BIT];
                  role_r <= RL_WORD;
                end
              end
              RL_WORD: begin
                ptr_r <= rxsh_r;
                role_r <= RL_DATA;
                if (!blk_rtc) begin
                  ppage_r <= rxsh_r[7:3];
                  pblk_r <= blk_r;
                end
              end
              RL_DATA: begin
                if (blk_rtc) begin
                  ptr_r <= rtc_next;
                end else begin
                  pbuf_r[ptr_r[2:0]] <= rxsh_r;
                  pmask_r[ptr_r[2:0]] <= 1'b1;
                  ptr_r <= page_next;
                end
              end
              default: role_r <= RL_ADDR;
            endcase
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            if (read_begin) begin
              txsh_r <= tx_load;
              sda_oe <= tx_load_oe;
              cnt_r <= 4'h1;
              ptr_r <= ptr_inc;
              st_r <= ST_TX;
            end else begin
              sda_oe <= 1'b0;
              st_r <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              sda_oe <= 1'b0;
              st_r <= ST_TX_ACK;
            end else begin
              sda_oe <= tx_bit_oe;
              txsh_r <= {txsh_r[6:0], 1'b0};
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            more_r <= ~sda_s;
          end else if (scl_fall) begin
            if (more_r) begin
              txsh_r <= tx_load;
              sda_oe <= tx_load_oe;
              cnt_r <= 4'h1;
              ptr_r <= ptr_inc;
              st_r <= ST_TX;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Commit and write cycle
  // ----------------------------------------
  // Commit yields to a clock-block write so both share one write port.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      commit_r <= 1'b0;
      cidx_r <= 3'h0;
      cmask_r <= 8'h00;
      wcnt_r <= 18'h0_0000;
      write_busy <= 1'b0;
    end else if (commit_start) begin
      // STOP starts commit
      // Own copy of the fill mask: the engine clears its mask at this STOP
      cmask_r <= pmask_r;
      commit_r <= 1'b1;
      cidx_r <= 3'h0;
      write_busy <= 1'b1;
    end else if (commit_r) begin
      if (commit_step) begin
        cidx_r <= cidx_r + 3'h1;
        if (commit_last) begin
          commit_r <= 1'b0;
          wcnt_r <= wlen;
        end
      end
    end else if (cycle_run) begin
      wcnt_r <= wcnt_r - 18'h0_0001;
    end else begin
      wcnt_r <= 18'h0_0000;
      write_busy <= 1'b0;
    end
  end
endmodule

// file: rei_slave_assertions.sv
module rei_slave_assertions #(
  parameter int WRITE_CYCLES = 20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Status
  input wire logic write_busy
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  localparam int BUSY_MIN = WRITE_CYCLES + 5;
  localparam int BUSY_MAX = WRITE_CYCLES + 20;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sda_out_zero_a: assert property (!sda_out)
    else $error("sda_out not low");
  reset_quiet_a: assert property (!$past(rst_b) |-> !sda_oe && !write_busy)
    else $error("outputs active after reset");
  // ACK and data change only while SCL is low
  oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda_oe rose with scl high");
  oe_fall_low_a: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("sda_oe fell with scl high");
  oe_stable_high_a: assert property ($rose(scl_in) |-> ##1 $stable(sda_oe) [*2])
    else $error("sda_oe moved in scl high");
  oe_bounded_a: assert property ($rose(sda_oe) |-> ##[1:80] !sda_oe)
    else $error("sda_oe held too long");
  busy_stop_a: assert property ($rose(write_busy) |-> scl_in && sda_in && !sda_oe)
    else $error("busy without stop");
  busy_hold_a: assert property ($rose(write_busy) |-> ##BUSY_MIN write_busy)
    else $error("write cycle too short");
  busy_end_a: assert property ($rose(write_busy) |-> ##[BUSY_MIN:BUSY_MAX] !write_busy)
    else $error("write cycle too long");
  cover property ($rose(write_busy));
  cover property ($fell(write_busy));
  cover property ($rose(sda_oe) ##[1:80] $fell(sda_oe));
endmodule

bind rei_slave rei_slave_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (.clock(clock),
  .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .write_busy(write_busy));

// file: rei_master.sv
module rei_master (
  // Clock
  input wire logic clock,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  timeunit 1ns;
  timeprecision 1ps;
  // SCL stands high between frames
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Data moves one clock after SCL falls, so it never looks like START or STOP
  task automatic bt(input logic b, output logic r);
    w(1);
    sda_m = b;
    w(3);
    scl = 1'b1;
    w(4);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    w(1);
    sda_m = 1'b1;
    w(3);
    scl = 1'b1;
    w(2);
    sda_m = 1'b0;
    w(2);
    scl = 1'b0;
  endtask
  task automatic stop();
    w(1);
    sda_m = 1'b0;
    w(3);
    scl = 1'b1;
    w(2);
    sda_m = 1'b1;
    w(4);
  endtask
  task automatic wb(input logic [7:0] d, output logic [7:0] ack);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    ack = {7'h00, ~r};
  endtask
  task automatic rb(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
    bt(~mack, r);
  endtask
endmodule

// file: rei_slave_bench.sv
module rei_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rei_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic sda_out, sda_oe, write_busy, scl, sda_m, sda;
  logic [7:0] mir [0:2][0:255];
  int errors = 0;
  int checked = 0;
  int seed = 98;
  always #12.5 clock = ~clock;
  assign sda = sda_m & ~sda_oe;
  rei_master mst_u (.clock(clock), .sda(sda), .scl(scl), .sda_m(sda_m));
  rei_slave #(.WRITE_CYCLES(200)) dut_u (.clock(clock), .rst_b(rst_b), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Select MSB kept 0 by callers
  function automatic logic [7:0] ab(input logic [2:0] s, input logic r);
    return {REI_CTRL_CODE, s, r};
  endfunction
  // Pointer wraps: clock block, page on write, whole block on read
  function automatic logic [7:0] nx(input logic [2:0] s, input logic [7:0] p, input logic w);
    if (s == REI_SEL_RTC) return (p + 8'h01) & (REI_RTC_BYTES - 8'h01);
    if (w) return {p[7:3], p[2:0] + 3'h1};
    return p + 8'h01;
  endfunction
  task automatic wr(input logic [2:0] s, input logic [7:0] p, input int n);
    logic [7:0] a, d;
    mst_u.start();
    mst_u.wb(ab(s, 1'b0), a);
    chk(a, 8'h01);
    mst_u.wb(p, a);
    chk(a, 8'h01);
    repeat (n) begin
      d = 8'($random(seed));
      mst_u.wb(d, a);
      chk(a, 8'h01);
      mir[s][p] = d;
      p = nx(s, p, 1'b1);
    end
    mst_u.stop();
  endtask
  task automatic rd(input logic [2:0] s, input logic [7:0] p, input int n, input logic ld);
    logic [7:0] a, d;
    if (ld) begin
      mst_u.start();
      mst_u.wb(ab(s, 1'b0), a);
      mst_u.wb(p, a);
    end
    mst_u.start();
    mst_u.wb(ab(s, 1'b1), a);
    chk(a, 8'h01);
    for (int i = 1; i <= n; i++) begin
      mst_u.rb(i < n, d);
      chk(d, mir[s][p]);
      p = nx(s, p, 1'b0);
    end
    mst_u.stop();
  endtask
  task automatic poll(input logic [7:0] f);
    logic [7:0] a;
    chk({7'h00, write_busy}, {7'h00, ~f[0]});
    mst_u.start();
    mst_u.wb(ab(REI_SEL_LOW, 1'b0), a);
    chk(a, f);
    for (int k = 0; k < 20 && a !== 8'h01; k++) begin
      mst_u.start();
      mst_u.wb(ab(REI_SEL_LOW, 1'b0), a);
    end
    mst_u.stop();
    chk({7'h00, write_busy}, 8'h00);
    if (a !== 8'h01) begin
      chk(a, 8'h01);
      end_of_test();
    end
  endtask
  initial begin
    logic [7:0] a, d;
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    wr(REI_SEL_LOW, 8'h08, 8);
    poll(8'h00);
    wr(REI_SEL_LOW, 8'h0E, 4);
    // Clock block stays open while memory is busy
    wr(REI_SEL_RTC, 8'h0E, 20);
    poll(8'h01);
    wr(REI_SEL_UP, 8'hFB, 10);
    poll(8'h00);
    wr(REI_SEL_UP, 8'h00, 2);
    poll(8'h00);
    rd(REI_SEL_LOW, 8'h08, 7, 1'b1);
    rd(REI_SEL_LOW, 8'h0F, 1, 1'b0);
    rd(REI_SEL_RTC, 8'h05, 16, 1'b1);
    rd(REI_SEL_UP, 8'hFC, 6, 1'b1);
    // Unused select 011 and foreign control codes are refused
    for (int s = 3; s < 9; s++) begin
      d = (s == 3) ? ab(3'h3, 1'b0) : {REI_CTRL_CODE ^ 4'(s), 4'h0};
      mst_u.start();
      mst_u.wb(d, a);
      chk(a, 8'h00);
      mst_u.stop();
    end
    end_of_test();
  end
endmodule
